// [design/tsb_irq_logic.sv]
// Purpose: vectored interrupt requester for a serial line interface
// Assumes: rx_done/tx_done come from logic on pclk; bus pins are async
// Notes:   bus handshake signals are active high inside this block
//
// Implementation choices: the register offsets and the APB register port.
`default_nettype none

module tsb_irq_logic #(
    parameter logic [8:0] VEC_BASE = tsb_pkg::VEC_BASE_DEF
) (
    // clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [tsb_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [tsb_pkg::DATA_W-1:0]  pwdata,
    output logic      [tsb_pkg::DATA_W-1:0]  prdata,
    output logic                             pready,
    output logic                             pslverr,
    // done flags from receiver and transmitter
    input  wire logic                        rx_done,
    input  wire logic                        tx_done,
    // bus pins
    input  wire logic                        bus_init_i,
    input  wire logic                        grant_in_i,
    output logic                             grant_out_o,
    input  wire logic                        npr_i,
    input  wire logic                        ssyn_i,
    output logic                             bus_request_o,
    output logic                             sack_o,
    input  wire logic                        bbsy_i,
    output logic                             bbsy_o,
    output logic                             bbsy_oe_o,
    output logic                             intr_o,
    output logic      [tsb_pkg::VEC_W-1:0]   vec_o,
    output logic                             vec_oe_o,
    // interrupt
    output logic                             irq
);
    import tsb_pkg::*;

    // synchronised pins
    logic [4:0] pins_s;
    logic       init_s;
    logic       grant_s;
    logic       npr_s;
    logic       ssyn_s;
    logic       bbsy_s;

    tsb_sync #(.WIDTH(5)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .async_i ({bus_init_i, grant_in_i, npr_i, ssyn_i, bbsy_i}),
        .sync_o  (pins_s)
    );
    assign {init_s, grant_s, npr_s, ssyn_s, bbsy_s} = pins_s;

    // apb decode
    logic setup;
    logic access;
    logic wr_en;
    logic rx_csr_rd;
    logic lock_rel;

    assign setup     = psel & ~penable;
    assign access    = psel & penable;
    assign wr_en     = access & pwrite;
    assign rx_csr_rd = access & ~pwrite & (paddr == RX_CSR_ADDR);
    assign pready    = 1'b1;

    // lockout release after the status read
    tsb_delay #(.CYCLES(LOCK_REL_CYC)) u_lock_dly (
        .pclk    (pclk),
        .presetn (presetn),
        .start_i (rx_csr_rd),
        .done_o  (lock_rel)
    );

    // state
    tsb_state_t         state_q, state_d;
    logic               rx_ie_q, rx_ie_d;
    logic               tx_ie_q, tx_ie_d;
    logic               rx_done_q;
    logic               tx_done_q;
    logic               rx_req_q, rx_req_d;
    logic               tx_req_q, tx_req_d;
    logic               rx_lock_q, rx_lock_d;
    logic               vsel_q, vsel_d;
    logic [INT_N-1:0]   int_stat_q, int_stat_d;
    logic [INT_N-1:0]   int_en_q, int_en_d;
    logic [INT_N-1:0]   int_set;
    logic [DATA_W-1:0]  prdata_d;
    logic               pslverr_d;
    logic               br_d, sack_d, busy_d, intr_d;
    logic [VEC_W-1:0]   vec_d;
    logic               combined_irq_request;
    logic               grant_pass_enable;
    logic               irq_clear_pulse;
    logic               bus_busy_ff;

    assign irq_clear_pulse = (state_q == TSB_CLEAR);
    assign bus_busy_ff     = bbsy_oe_o;
    // request drops for the clear pulse and re-arms after it
    assign combined_irq_request =
        (rx_req_q | tx_req_q) & ~irq_clear_pulse;

    assign grant_pass_enable =
        (bus_busy_ff | ~combined_irq_request) & ~npr_s;
    // combinational so a passed grant costs no extra cycle
    assign grant_out_o = grant_s & grant_pass_enable;

    always_comb begin
        state_d  = state_q;
        rx_req_d = rx_req_q;
        tx_req_d = tx_req_q;
        vsel_d   = vsel_q;
        br_d     = 1'b0;
        sack_d   = 1'b0;
        busy_d   = 1'b0;
        intr_d   = 1'b0;
        vec_d    = '0;
        int_set  = '0;
        rx_lock_d = rx_lock_q;
        if (lock_rel) begin
            rx_lock_d = 1'b0;
        end
        // new rising done edges latch requests
        if (rx_done & ~rx_done_q & rx_ie_q & ~rx_lock_q) begin
            rx_req_d = 1'b1;
        end
        if (tx_done & ~tx_done_q & tx_ie_q) begin
            tx_req_d = 1'b1;
        end
        unique case (state_q)
            TSB_IDLE: begin
                if (combined_irq_request) begin
                    state_d = TSB_REQ;
                    br_d    = 1'b1;
                end
            end
            TSB_REQ: begin
                br_d = 1'b1;
                if (grant_s) begin
                    state_d = TSB_SACK;
                    br_d    = 1'b0;
                    sack_d  = 1'b1;
                end
            end
            TSB_SACK: begin
                sack_d = 1'b1;
                // grant removal by the processor, with bbsy and ssyn idle, ends this wait
                if (~grant_s & ~bbsy_s & ~ssyn_s) begin
                    state_d = TSB_MASTER;
                    sack_d  = 1'b0;
                    busy_d  = 1'b1;
                    intr_d  = 1'b1;
                    // receive outranks transmit
                    vsel_d  = rx_req_q;
                    vec_d   = VEC_BASE;
                    vec_d[VEC_TX_BIT] = ~rx_req_q;
                end
            end
            TSB_MASTER: begin
                busy_d = 1'b1;
                intr_d = 1'b1;
                vec_d  = VEC_BASE;
                vec_d[VEC_TX_BIT] = ~vsel_q;
                // ssyn arrives after the processor skew wait
                if (ssyn_s) begin
                    state_d = TSB_CLEAR;
                    busy_d  = 1'b0;
                    intr_d  = 1'b0;
                    vec_d   = '0;
                    if (vsel_q) begin
                        rx_req_d  = 1'b0;
                        rx_lock_d = 1'b1;
                        int_set[INT_RX_BIT] = 1'b1;
                    end else begin
                        tx_req_d = 1'b0;
                        int_set[INT_TX_BIT] = 1'b1;
                    end
                end
            end
            TSB_CLEAR: begin
                // one cycle pulse, then pending tx re-requests
                state_d = TSB_IDLE;
            end
        endcase
        if (init_s) begin
            state_d   = TSB_IDLE;
            rx_req_d  = 1'b0;
            tx_req_d  = 1'b0;
            rx_lock_d = 1'b0;
            vsel_d    = 1'b0;
            br_d      = 1'b0;
            sack_d    = 1'b0;
            busy_d    = 1'b0;
            intr_d    = 1'b0;
            vec_d     = '0;
            int_set[INT_INIT_BIT] = 1'b1;
        end
    end

    // register file
    always_comb begin
        rx_ie_d   = rx_ie_q;
        tx_ie_d   = tx_ie_q;
        int_en_d  = int_en_q;
        prdata_d  = prdata;
        pslverr_d = 1'b0;
        // set beats clear in the same cycle
        int_stat_d = int_stat_q | int_set;
        if (wr_en) begin
            unique case (paddr)
                RX_CSR_ADDR:   rx_ie_d  = pwdata[CSR_IE_BIT];
                TX_CSR_ADDR:   tx_ie_d  = pwdata[CSR_IE_BIT];
                INT_EN_ADDR:   int_en_d = pwdata[INT_N-1:0];
                INT_CLR_ADDR:  int_stat_d =
                    (int_stat_q & ~pwdata[INT_N-1:0]) | int_set;
                default: ;
            endcase
        end
        if (setup) begin
            prdata_d = '0;
            unique case (paddr)
                RX_CSR_ADDR: begin
                    prdata_d[CSR_IE_BIT]   = rx_ie_q;
                    prdata_d[CSR_DONE_BIT] = rx_done;
                end
                TX_CSR_ADDR: begin
                    prdata_d[CSR_IE_BIT]   = tx_ie_q;
                    prdata_d[CSR_DONE_BIT] = tx_done;
                end
                INT_STAT_ADDR: prdata_d[INT_N-1:0] = int_stat_q;
                INT_EN_ADDR:   prdata_d[INT_N-1:0] = int_en_q;
                INT_CLR_ADDR:  ;
                BUS_STAT_ADDR: prdata_d[7:0] = {rx_lock_q, vsel_q,
                    rx_req_q, tx_req_q, 1'b0, state_q};
                default:       ;
            endcase
        end
        if (access) begin
            pslverr_d = ~((paddr == RX_CSR_ADDR) | (paddr == TX_CSR_ADDR)
                | (paddr == INT_STAT_ADDR) | (paddr == INT_EN_ADDR)
                | (paddr == INT_CLR_ADDR) | (paddr == BUS_STAT_ADDR));
        end
    end

    assign pslverr = access & pslverr_d;
    assign irq     = |(int_stat_q & int_en_q);
    assign bbsy_o  = 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q       <= TSB_IDLE;
            rx_ie_q       <= 1'b0;
            tx_ie_q       <= 1'b0;
            rx_done_q     <= 1'b0;
            tx_done_q     <= 1'b0;
            rx_req_q      <= 1'b0;
            tx_req_q      <= 1'b0;
            rx_lock_q     <= 1'b0;
            vsel_q        <= 1'b0;
            int_stat_q    <= '0;
            int_en_q      <= '0;
            prdata        <= '0;
            bus_request_o <= 1'b0;
            sack_o        <= 1'b0;
            bbsy_oe_o     <= 1'b0;
            intr_o        <= 1'b0;
            vec_o         <= '0;
            vec_oe_o      <= 1'b0;
        end else begin
            state_q       <= state_d;
            rx_ie_q       <= rx_ie_d;
            tx_ie_q       <= tx_ie_d;
            rx_done_q     <= rx_done;
            tx_done_q     <= tx_done;
            rx_req_q      <= rx_req_d;
            tx_req_q      <= tx_req_d;
            rx_lock_q     <= rx_lock_d;
            vsel_q        <= vsel_d;
            int_stat_q    <= int_stat_d;
            int_en_q      <= int_en_d;
            prdata        <= prdata_d;
            bus_request_o <= br_d;
            sack_o        <= sack_d;
            bbsy_oe_o     <= busy_d;
            intr_o        <= intr_d;
            vec_o         <= vec_d;
            vec_oe_o      <= busy_d;
        end
    end
endmodule : tsb_irq_logic

`default_nettype wire

// [design/tsb_pkg.sv]
// Purpose: constants and types shared by the two-source bus interrupt logic
// Assumes: 200 MHz pclk, APB register access, 32-bit data
// Notes:   vector base is fixed by configuration; bit 2 marks transmit
//
// Functional notes
// - rx request needs rx enable and rx done; tx needs tx enable, tx done.
// - when both are pending, receive is serviced first, then transmit.
// - rx done sets rx request latch, combined request and bus request.
// - grant while pending: assert sack, drop bus request, block grant.
// - bbsy and ssyn idle: drop sack, set select, drive bbsy, intr, vector.
// - ssyn makes clear pulse; on an rx service it sets rx lockout blocking rx requests.
// - clear pulse drops combined request, busy, bbsy, intr and vector.
// - tx done sets its own latch, held while rx is being served.
// - pending tx re-raises combined and bus request after clear pulse.
// - reading rx control/status clears rx lockout 20 ns later.
// - transmit interrupt resets select flip-flop, driving vector bit 2.
// - grant-pass enable: (busy or no request) and npr inactive.
// - incoming grant passes downstream while grant-pass enable is true.
// - npr line always blocks grant from passing downstream.
`default_nettype none

package tsb_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          VEC_W         = 9;
    localparam int          VEC_TX_BIT    = 2;
    // register byte addresses
    localparam logic [7:0]  RX_CSR_ADDR   = 8'h00;
    localparam logic [7:0]  TX_CSR_ADDR   = 8'h04;
    localparam logic [7:0]  INT_STAT_ADDR = 8'h08;
    localparam logic [7:0]  INT_EN_ADDR   = 8'h0c;
    localparam logic [7:0]  INT_CLR_ADDR  = 8'h10;
    localparam logic [7:0]  BUS_STAT_ADDR = 8'h14;
    // control/status fields
    localparam int          CSR_IE_BIT    = 6;
    localparam int          CSR_DONE_BIT  = 7;
    localparam int          INT_N         = 3;
    localparam int          INT_RX_BIT    = 0;
    localparam int          INT_TX_BIT    = 1;
    localparam int          INT_INIT_BIT  = 2;
    localparam logic [8:0]  VEC_BASE_DEF  = 9'h030;
    // lockout release delay
    localparam int          CLK_PERIOD_PS = 5000;
    localparam int          LOCK_REL_PS   = 20000;
    localparam int          LOCK_REL_CYC  =
        (LOCK_REL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          SYNC_STAGES   = 2;

    typedef enum logic [2:0] {
        TSB_IDLE,
        TSB_REQ,
        TSB_SACK,
        TSB_MASTER,
        TSB_CLEAR
    } tsb_state_t;
endpackage : tsb_pkg

`default_nettype wire

// [design/tsb_sync.sv]
// Purpose: two flip-flop synchroniser for bus pins
// Assumes: inputs asynchronous to pclk
// Notes:   first stage is read by the second stage only
`default_nettype none

module tsb_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : tsb_sync

`default_nettype wire

// [design/tsb_delay.sv]
// Purpose: fires a one-cycle pulse a fixed number of cycles after a start
// Assumes: start pulse is one cycle wide
// Notes:   a new start restarts the count
`default_nettype none

module tsb_delay #(
    parameter int CYCLES = 4
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control
    input  wire logic start_i,
    output logic      done_o
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       done_d;

    always_comb begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (start_i) begin
            cnt_d = 4'(CYCLES);
        end else if (cnt_q != 4'h0) begin
            cnt_d  = cnt_q - 4'h1;
            done_d = (cnt_q == 4'h1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= 4'h0;
            done_o <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            done_o <= done_d;
        end
    end
endmodule : tsb_delay

`default_nettype wire

// [tb/tsb_irq_chk.sv]
// Purpose: bus handshake checks for tsb_irq_logic
// Assumes: single pclk domain; pins pass a two-stage synchroniser
// Notes:   windows allow the two-cycle pin latency plus one fsm edge
`default_nettype none

module tsb_irq_chk #(
    parameter logic [8:0] VEC_BASE = tsb_pkg::VEC_BASE_DEF
) (
    // clock and reset
    input wire logic                      pclk,
    input wire logic                      presetn,
    // bus pins
    input wire logic                      bus_init_i,
    input wire logic                      grant_in_i,
    input wire logic                      grant_out_o,
    input wire logic                      npr_i,
    input wire logic                      ssyn_i,
    input wire logic                      bus_request_o,
    input wire logic                      sack_o,
    input wire logic                      bbsy_oe_o,
    input wire logic                      intr_o,
    input wire logic [tsb_pkg::VEC_W-1:0] vec_o,
    input wire logic                      vec_oe_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import tsb_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // grant held long enough to cross the synchroniser
    sequence s_granted;
        bus_request_o && grant_in_i ##1 grant_in_i [*2];
    endsequence
    sequence s_acked;
        intr_o && ssyn_i ##1 ssyn_i [*2];
    endsequence

    a_grant_sack: assert property (s_granted |=> sack_o)
        else $error("sack missing after grant");
    a_sack_drops_br: assert property ($rose(sack_o) |-> !bus_request_o)
        else $error("bus request kept with sack");
    a_grant_blocked: assert property (sack_o |-> !grant_out_o)
        else $error("grant passed while acknowledging");
    a_npr_blocks: assert property (npr_i [*3] |-> !grant_out_o)
        else $error("grant passed during npr");
    a_intr_drive: assert property (intr_o |-> vec_oe_o && bbsy_oe_o)
        else $error("intr without busy or vector");
    // a bus init seen three edges back also drops sack, legally
    a_sack_to_intr: assert property ($fell(sack_o) &&
        !$past(bus_init_i, 3) |-> intr_o)
        else $error("sack released without intr");
    a_vec_base: assert property (intr_o |->
        (vec_o & 9'h1fb) == (VEC_BASE & 9'h1fb))
        else $error("vector base wrong");
    a_ssyn_release: assert property (s_acked |=>
        !intr_o && !vec_oe_o && !bbsy_oe_o)
        else $error("outputs held after ssyn");
    a_init_clear: assert property (bus_init_i [*5] |->
        !bus_request_o && !intr_o && !sack_o)
        else $error("request left after init");
endmodule : tsb_irq_chk

bind tsb_irq_logic tsb_irq_chk #(.VEC_BASE(VEC_BASE)) i_tsb_irq_chk (
    .pclk(pclk),
    .presetn(presetn),
    .bus_init_i(bus_init_i),
    .grant_in_i(grant_in_i),
    .grant_out_o(grant_out_o),
    .npr_i(npr_i),
    .ssyn_i(ssyn_i),
    .bus_request_o(bus_request_o),
    .sack_o(sack_o),
    .bbsy_oe_o(bbsy_oe_o),
    .intr_o(intr_o),
    .vec_o(vec_o),
    .vec_oe_o(vec_oe_o)
);

`default_nettype wire

// [tb/tsb_arb.sv]
// Purpose: processor arbiter model facing the interrupt logic
// Assumes: grant delay set by the bench, prompt or slow
// Notes:   captures the vector at the edge it raises ssyn
`default_nettype none

module tsb_arb (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // device side
    input  wire logic       br,
    input  wire logic       sack,
    input  wire logic       intr,
    input  wire logic [8:0] vec,
    output logic            grant,
    output logic            ssyn,
    // bench control
    input  wire logic       hold_grant,
    input  wire logic [7:0] grant_delay,
    output logic [8:0]      got_vec
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       grant_q;
    logic [7:0] gcnt_q;
    logic [3:0] wcnt_q;

    assign grant = grant_q | hold_grant;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grant_q <= 1'b0;
            ssyn    <= 1'b0;
            gcnt_q  <= 8'h00;
            wcnt_q  <= 4'h0;
            got_vec <= 9'h000;
        end else begin
            if (sack) begin
                grant_q <= 1'b0;
            end else if (br && !grant_q) begin
                gcnt_q <= gcnt_q + 8'h01;
                if (gcnt_q >= grant_delay) begin
                    grant_q <= 1'b1;
                end
            end else begin
                gcnt_q <= 8'h00;
            end
            // skew wait of 15 cycles, 75 ns at 200 MHz
            if (!intr) begin
                ssyn   <= 1'b0;
                wcnt_q <= 4'h0;
            end else if (!ssyn) begin
                wcnt_q <= wcnt_q + 4'h1;
                if (wcnt_q == 4'he) begin
                    ssyn    <= 1'b1;
                    got_vec <= vec;
                end
            end
        end
    end
endmodule : tsb_arb

`default_nettype wire

// [tb/two_source_bus_interrupt_logic_bench.sv]
// Purpose: apb and bus handshake scenarios for tsb_irq_logic
// Assumes: arbiter model on the bus pins, 200 MHz pclk
// Notes:   odd vector base so a stuck default would show
`default_nettype none

module two_source_bus_interrupt_logic_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import tsb_pkg::*;
    localparam logic [8:0]  VB = 9'h0a8;
    localparam logic [31:0] IE = 32'h1 << CSR_IE_BIT;
    localparam logic [31:0] DN = 32'h1 << CSR_DONE_BIT;
    localparam logic [31:0] RXI = 32'h1 << INT_RX_BIT;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        rx_done, tx_done, bus_init_i, npr_i, hold, err;
    logic        grant_in_i, grant_out_o, ssyn_i, bus_request_o, sack_o;
    logic        bbsy_o, bbsy_oe_o, intr_o, vec_oe_o, irq;
    logic [7:0]  paddr, gdel;
    logic [31:0] pwdata, prdata, r;
    logic [8:0]  vec_o, got_vec;
    int          failures, n_checks;

    tsb_irq_logic #(.VEC_BASE(VB)) i_tsb_irq_logic (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_done(rx_done),
        .tx_done(tx_done), .bus_init_i(bus_init_i),
        .grant_in_i(grant_in_i), .grant_out_o(grant_out_o), .npr_i(npr_i),
        .ssyn_i(ssyn_i), .bus_request_o(bus_request_o), .sack_o(sack_o),
        .bbsy_i(bbsy_oe_o & bbsy_o), .bbsy_o(bbsy_o),
        .bbsy_oe_o(bbsy_oe_o), .intr_o(intr_o), .vec_o(vec_o),
        .vec_oe_o(vec_oe_o), .irq(irq));

    tsb_arb i_tsb_arb (
        .pclk(pclk), .presetn(presetn), .br(bus_request_o), .sack(sack_o),
        .intr(intr_o), .vec(vec_o), .grant(grant_in_i), .ssyn(ssyn_i),
        .hold_grant(hold), .grant_delay(gdel), .got_vec(got_vec));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic give_verdict;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // bounded wait, sampled 1 ns after the edge so outputs have settled
    task automatic wt(ref logic s, input logic v, input string nm);
        int k;
        for (k = 0; k < 400; k++) begin
            @(posedge pclk);
            #1;
            if (s === v) break;
        end
        chk(nm, v, s);
        if (k == 400) give_verdict();
    endtask : wt

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            chk("pready", 1, pready);
            give_verdict();
        end
        r       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic serve(input logic [8:0] v);
        wt(ssyn_i, 1'b1, "ssyn");
        chk("vector", v, got_vec);
        wt(ssyn_i, 1'b0, "ssyn release");
    endtask : serve

    initial begin
        {psel, penable, pwrite, rx_done, tx_done} = '0;
        {bus_init_i, npr_i, hold, presetn} = '0;
        {paddr, pwdata, gdel, failures, n_checks} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, RX_CSR_ADDR, 0);
        chk("rx csr reset", 0, r);
        apb(0, BUS_STAT_ADDR, 0);
        chk("bus status reset", 0, r);
        apb(1, 8'h18, 32'h1);
        chk("unmapped error", 1, err);
        apb(0, 8'h18, 0);
        chk("unmapped data", 0, r);
        @(posedge pclk);
        rx_done <= 1'b1;
        tx_done <= 1'b1;
        repeat (10) @(posedge pclk);
        chk("request disabled", 0, bus_request_o);
        rx_done <= 1'b0;
        tx_done <= 1'b0;
        apb(1, RX_CSR_ADDR, IE);
        apb(1, TX_CSR_ADDR, IE);
        apb(1, INT_EN_ADDR, 32'h3);
        // both flags at one edge: receive must win
        @(posedge pclk);
        rx_done <= 1'b1;
        tx_done <= 1'b1;
        wt(bus_request_o, 1'b1, "bus request");
        serve(VB);
        serve(VB | 9'h004);
        apb(0, INT_STAT_ADDR, 0);
        chk("status both", 3, r);
        apb(1, INT_EN_ADDR, 0);
        apb(0, INT_STAT_ADDR, 0);
        chk("irq masked", 0, irq);
        apb(1, INT_EN_ADDR, 32'h3);
        // irq follows the enable write only after that edge has settled
        @(negedge pclk);
        chk("irq raised", 1, irq);
        apb(1, INT_CLR_ADDR, 32'h3);
        apb(0, INT_STAT_ADDR, 0);
        chk("status cleared", 0, r);
        chk("irq cleared", 0, irq);
        // new receive flag stays locked out until the status read
        @(posedge pclk);
        rx_done <= 1'b0;
        @(posedge pclk);
        rx_done <= 1'b1;
        repeat (10) @(posedge pclk);
        chk("request locked", 0, bus_request_o);
        apb(0, RX_CSR_ADDR, 0);
        chk("rx csr", IE | DN, r);
        rx_done <= 1'b0;
        repeat (6) @(posedge pclk);
        rx_done <= 1'b1;
        serve(VB);
        @(posedge pclk);
        hold <= 1'b1;
        wt(grant_out_o, 1'b1, "grant passed");
        @(posedge pclk);
        npr_i <= 1'b1;
        wt(grant_out_o, 1'b0, "grant blocked");
        @(posedge pclk);
        npr_i   <= 1'b0;
        hold    <= 1'b0;
        gdel    <= 8'h64;
        tx_done <= 1'b0;
        @(posedge pclk);
        tx_done <= 1'b1;
        wt(bus_request_o, 1'b1, "slow request");
        @(posedge pclk);
        bus_init_i <= 1'b1;
        repeat (6) @(posedge pclk);
        bus_init_i <= 1'b0;
        chk("request after init", 0, bus_request_o);
        apb(0, INT_STAT_ADDR, 0);
        // rx delivery from the lockout release run is still recorded
        chk("init status", RXI | (32'h1 << INT_INIT_BIT), r);
        apb(0, BUS_STAT_ADDR, 0);
        chk("bus status init", 0, r);
        repeat (120) @(posedge pclk);
        chk("no late request", 0, bus_request_o);
        give_verdict();
    end
endmodule : two_source_bus_interrupt_logic_bench

`default_nettype wire
